// File: core/mcu_cfg.svh
// Constants of the memory check unit: offsets, fields, reset values, timing.
// Assumes inclusion by the core module only.
`ifndef MCU_CFG_SVH
`define MCU_CFG_SVH

// ****************************************
// Register offsets (printed indices, byte address = 4 * index)
// ****************************************
`define MCU_IDX_CONTROL 8'h00
`define MCU_IDX_CONFIG 8'h01
`define MCU_IDX_STATUS 8'h02
`define MCU_ADDR_CONTROL 12'h000
`define MCU_ADDR_CONFIG 12'h004
`define MCU_ADDR_STATUS 12'h008
`define MCU_ADDR_FLASH_END 12'h00c
`define MCU_ADDR_APP_END 12'h010
`define MCU_ADDR_BOOT_END 12'h014

// ****************************************
// Field positions
// ****************************************
`define MCU_CTL_ENABLE 0
`define MCU_CTL_FIE 1
`define MCU_CTL_SRST 7
`define MCU_CFG_SEL_LSB 0
`define MCU_CFG_MODE_LSB 4
`define MCU_ST_BUSY 0
`define MCU_ST_PASS 1

// ****************************************
// Reset values and codes
// ****************************************
`define MCU_CONTROL_RST 8'h00
`define MCU_CONFIG_RST 8'h00
`define MCU_STATUS_RST 8'h02
`define MCU_CRC_INIT 16'hffff
`define MCU_CRC_POLY 16'h1021
`define MCU_SEL_FLASH 2'h0
`define MCU_SEL_BOOT_AND_APP_SECTIONS 2'h1
`define MCU_SEL_BOOT 2'h2
`define MCU_MODE_PRIORITY 2'h0
`define MCU_MODE_RESETSCAN 2'h1
`define MCU_FLASH_END_RST 16'h0fff
`define MCU_APP_END_RST 16'h0dff
`define MCU_BOOT_END_RST 16'h01ff

// ****************************************
// Timing
// ****************************************
`define MCU_START_CYCLES 2'd3
`define MCU_FETCH_CYCLES 2'd3

`endif

// File: core/mcu_pkg.sv
// Types of the memory check unit.
// Assumes the config header is on the include path.
package mcu_pkg;
   // APB request carried as one bundle
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } mcu_apb_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_SCAN,
      ST_CHECK
   } mcu_state_t;
endpackage

// File: core/mcu_memory_check_unit.sv
// Memory check unit: APB registers, flash walk, CRC-16 and pass/fail report.
// Assumes an APB master on MCLK and a flash read port answering in one cycle.
`timescale 1ns/10ps
`include "mcu_cfg.svh"

module mcu_memory_check_unit
   import mcu_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // System state
   input wire logic CPU_SLEEP,
   input wire logic BOOT_SCAN_REQ,
   input wire logic [1:0] BOOT_SCAN_SEL,
   // Flash read port
   output logic FLASH_REQ,
   output logic [15:0] FLASH_ADDR,
   input wire logic [15:0] FLASH_RDATA,
   input wire logic FLASH_VALID,
   output logic CPU_STALL,
   // Failure interrupt
   output logic NMI_REQ
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         if (c[15] ^ data[i]) begin
            c = {c[14:0], 1'b0} ^ `MCU_CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      return a == b;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   mcu_apb_req_t req;
   assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

   logic wr_access;
   logic rd_setup;
   assign wr_access = req.sel && req.enable && req.write && PREADY;
   assign rd_setup = req.sel && !req.enable;

   // ****************************************
   // State
   // ****************************************
   mcu_state_t state_q;
   logic enable_q;
   logic fie_q;
   logic [1:0] sel_q;
   logic [1:0] mode_q;
   logic busy_q;
   logic pass_q;
   logic nmi_q;
   logic srst_q;
   logic [1:0] start_cnt_q;
   logic [1:0] fetch_cnt_q;
   logic [15:0] addr_q;
   logic [15:0] end_q;
   logic [15:0] crc_q;
   logic [15:0] flash_end_q;
   logic [15:0] app_end_q;
   logic [15:0] boot_end_q;
   logic boot_scan_q;

   logic wr_ctl;
   logic wr_cfg;
   logic ctl_ok;
   logic start_req;
   logic fie_wr;
   logic srst_wr;
   logic done;
   logic mismatch;
   logic [15:0] crc_next;

   assign wr_ctl = wr_access && hit(req.addr, `MCU_ADDR_CONTROL);
   assign wr_cfg = wr_access && hit(req.addr, `MCU_ADDR_CONFIG)
      && !busy_q && !nmi_q;
   assign ctl_ok = wr_ctl && !nmi_q;
   assign start_req = ctl_ok && req.wdata[`MCU_CTL_ENABLE];
   assign fie_wr = ctl_ok && req.wdata[`MCU_CTL_FIE] && !busy_q;
   assign srst_wr = ctl_ok && req.wdata[`MCU_CTL_SRST] && (!fie_q || !busy_q);

   // Fed bytes high then low; the last word is the stored checksum
   assign crc_next = crc_byte(crc_byte(crc_q, FLASH_RDATA[15:8]), FLASH_RDATA[7:0]);
   // End index is inclusive: the checksum word itself must be fed too
   assign done = (state_q == ST_SCAN) && FLASH_VALID && (addr_q >= end_q);
   // Running the checksum over itself leaves zero on a match
   assign mismatch = crc_next != 16'h0000;

   // ****************************************
   // Soft reset strobe
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= srst_wr;
      end
   end

   // ****************************************
   // Section bounds (word addresses, last word inclusive)
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         flash_end_q <= `MCU_FLASH_END_RST;
         app_end_q <= `MCU_APP_END_RST;
         boot_end_q <= `MCU_BOOT_END_RST;
      end else if (wr_access && !busy_q) begin
         if (hit(req.addr, `MCU_ADDR_FLASH_END)) begin
            flash_end_q <= req.wdata[15:0];
         end
         if (hit(req.addr, `MCU_ADDR_APP_END)) begin
            app_end_q <= req.wdata[15:0];
         end
         if (hit(req.addr, `MCU_ADDR_BOOT_END)) begin
            boot_end_q <= req.wdata[15:0];
         end
      end
   end

   // ****************************************
   // Control and configuration registers
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         enable_q <= 1'b0;
         sel_q <= `MCU_SEL_FLASH;
         mode_q <= `MCU_MODE_PRIORITY;
         fie_q <= 1'b0;
         boot_scan_q <= 1'b0;
      end else begin
         boot_scan_q <= 1'b0;
         if (srst_q) begin
            enable_q <= 1'b0;
            sel_q <= `MCU_SEL_FLASH;
            mode_q <= `MCU_MODE_PRIORITY;
         end else if (BOOT_SCAN_REQ && state_q == ST_IDLE) begin
            // Reset-time scan leaves its footprint
            enable_q <= 1'b1;
            sel_q <= BOOT_SCAN_SEL;
            mode_q <= `MCU_MODE_RESETSCAN;
            boot_scan_q <= 1'b1;
         end else begin
            if (ctl_ok) begin
               enable_q <= req.wdata[`MCU_CTL_ENABLE];
            end
            if (wr_cfg) begin
               sel_q <= req.wdata[`MCU_CFG_SEL_LSB +: 2];
               mode_q <= req.wdata[`MCU_CFG_MODE_LSB +: 2];
            end
         end
         if (fie_wr) begin
            fie_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // Scan sequencer
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         start_cnt_q <= 2'd0;
         fetch_cnt_q <= 2'd0;
         addr_q <= 16'h0000;
         end_q <= 16'h0000;
         crc_q <= `MCU_CRC_INIT;
      end else if (srst_q) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_req || boot_scan_q) begin
                  state_q <= ST_WAIT;
                  busy_q <= 1'b1;
                  start_cnt_q <= 2'd1;
               end
            end
            ST_WAIT: begin
               // Counting pauses while the CPU sleeps
               if (!CPU_SLEEP) begin
                  if (start_cnt_q == `MCU_START_CYCLES - 2'd1) begin
                     state_q <= ST_SCAN;
                     addr_q <= 16'h0000;
                     crc_q <= `MCU_CRC_INIT;
                     fetch_cnt_q <= 2'd0;
                     case (sel_q)
                        `MCU_SEL_BOOT_AND_APP_SECTIONS: end_q <= app_end_q;
                        `MCU_SEL_BOOT: end_q <= boot_end_q;
                        default: end_q <= flash_end_q;
                     endcase
                  end else begin
                     start_cnt_q <= start_cnt_q + 2'd1;
                  end
               end
            end
            ST_SCAN: begin
               if (!CPU_SLEEP) begin
                  if (fetch_cnt_q == `MCU_FETCH_CYCLES - 2'd1) begin
                     fetch_cnt_q <= 2'd0;
                  end else begin
                     fetch_cnt_q <= fetch_cnt_q + 2'd1;
                  end
               end
               // A word in flight as sleep begins is still taken, never fetched twice
               if (FLASH_VALID) begin
                  crc_q <= crc_next;
                  addr_q <= addr_q + 16'd1;
                  if (done) begin
                     state_q <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Result and failure interrupt
   // ****************************************
   logic fail_q;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         pass_q <= 1'b1;
         fail_q <= 1'b0;
      end else if (srst_q) begin
         pass_q <= 1'b1;
         fail_q <= 1'b0;
      end else if (state_q == ST_IDLE && (start_req || boot_scan_q)) begin
         pass_q <= 1'b0;
      end else if (done) begin
         pass_q <= !mismatch;
         fail_q <= mismatch;
      end
   end

   // NMI stays until system reset; soft reset cannot drop it
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         nmi_q <= 1'b0;
      end else if (done && mismatch && fie_q) begin
         nmi_q <= 1'b1;
      end
   end

   // ****************************************
   // Register images
   // ****************************************
   logic [7:0] ctl_img;
   logic [7:0] cfg_img;
   logic [7:0] sts_img;

   // Soft-reset bit is a strobe and always reads zero
   always_comb begin
      ctl_img = 8'h00;
      ctl_img[`MCU_CTL_ENABLE] = enable_q;
      ctl_img[`MCU_CTL_FIE] = fie_q;
   end

   always_comb begin
      cfg_img = 8'h00;
      cfg_img[`MCU_CFG_SEL_LSB +: 2] = sel_q;
      cfg_img[`MCU_CFG_MODE_LSB +: 2] = mode_q;
   end

   always_comb begin
      sts_img = 8'h00;
      // Pass is hidden while busy so a stale result is never read
      sts_img[`MCU_ST_PASS] = pass_q && !busy_q;
      sts_img[`MCU_ST_BUSY] = busy_q;
   end

   // ****************************************
   // Flash port
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         FLASH_REQ <= 1'b0;
         FLASH_ADDR <= 16'h0000;
         CPU_STALL <= 1'b0;
         NMI_REQ <= 1'b0;
      end else begin
         // Sleep withdraws the request; flash answers one cycle later
         FLASH_REQ <= (state_q == ST_SCAN) && !CPU_SLEEP && !done && !srst_q
            && (fetch_cnt_q == `MCU_FETCH_CYCLES - 2'd2);
         FLASH_ADDR <= addr_q;
         CPU_STALL <= busy_q && !srst_q && (state_q != ST_CHECK);
         NMI_REQ <= nmi_q || (done && mismatch && fie_q);
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         // One wait state: ready rises in the second access cycle
         PREADY <= req.sel && req.enable && !PREADY;
         PSLVERR <= 1'b0;
         if (rd_setup && !req.write) begin
            case (req.addr)
               `MCU_ADDR_CONTROL: PRDATA <= {24'h0, ctl_img};
               `MCU_ADDR_CONFIG: PRDATA <= {24'h0, cfg_img};
               // Status: writes fall through, no write path exists
               `MCU_ADDR_STATUS: PRDATA <= {24'h0, sts_img};
               `MCU_ADDR_FLASH_END: PRDATA <= {16'h0, flash_end_q};
               `MCU_ADDR_APP_END: PRDATA <= {16'h0, app_end_q};
               `MCU_ADDR_BOOT_END: PRDATA <= {16'h0, boot_end_q};
               default: PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// File: bench/mcu_flash_model.sv
// Flash read port model for the memory check unit.
// Assumes one request at a time, answered on the next clock edge.
`timescale 1ns/10ps
module mcu_flash_model (
   // Clock
   input wire logic clk,
   // Read port
   input wire logic req,
   input wire logic [15:0] addr,
   output logic [15:0] rdata,
   output logic valid,
   // Stored checksum placement
   input wire logic [15:0] chk_addr,
   input wire logic [15:0] chk_word
);
   // ****************************************
   // Answer logic
   // ****************************************
   initial begin
      rdata = 16'h0000;
      valid = 1'b0;
   end
   always @(posedge clk) begin
      valid <= req;
      if (req) begin
         // Checksum word sits at the last word, high byte in the high half
         rdata <= (addr == chk_addr) ? chk_word : ({addr[7:0], ~addr[7:0]} ^ 16'h3c5a);
      end else begin
         // Released bus toggles so stale data is never mistaken for a reply
         rdata <= ~rdata;
      end
   end
endmodule

// File: bench/mcu_check_properties.sv
// Port-level checks of the memory check unit.
// Assumes binding into mcu_memory_check_unit, single clock MCLK.
`timescale 1ns/10ps
module mcu_check_properties (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic PREADY,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   // Scan side
   input wire logic CPU_SLEEP,
   input wire logic FLASH_REQ,
   input wire logic [15:0] FLASH_ADDR,
   input wire logic CPU_STALL,
   input wire logic NMI_REQ
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   // Enable write from idle, no sleep, so the start is not deferred
   wire logic go = PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000 && PWDATA[0]
      && !PWDATA[7] && !CPU_STALL && !NMI_REQ && !CPU_SLEEP;
   a_start_delay: assert property (go |=> !FLASH_REQ[*2] ##[1:3] FLASH_REQ)
      else $error("scan start delay wrong");
   // Soft-reset write on the control register, accepted or not
   wire logic srst_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000 && PWDATA[7];
   // Busy is set at the next edge, the registered stall one edge later
   a_busy_rise: assert property (go |=> ##1 CPU_STALL)
      else $error("busy not raised by enable");
   a_fetch_space: assert property (FLASH_REQ |=> !FLASH_REQ[*2])
      else $error("flash fetches too close");
   a_sleep_halt: assert property (CPU_SLEEP[*3] |-> !FLASH_REQ)
      else $error("fetch during sleep");
   // A soft reset aborts the scan at once and legally drops the stall early
   a_stall_span: assert property (FLASH_REQ && !srst_wr && !$past(srst_wr) |=> CPU_STALL[*2])
      else $error("stall released before word consumed");
   a_addr_step: assert property (FLASH_REQ ##3 FLASH_REQ |->
      FLASH_ADDR == $past(FLASH_ADDR, 3) + 16'h1) else $error("flash address not ascending");
   a_nmi_sticky: assert property (NMI_REQ |=> NMI_REQ)
      else $error("failure interrupt dropped");
   a_nmi_cause: assert property ($rose(NMI_REQ) |-> $past(CPU_STALL) || $past(CPU_STALL, 2))
      else $error("failure interrupt without a check");
endmodule

bind mcu_memory_check_unit mcu_check_properties u_chk (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PADDR(PADDR), .PWDATA(PWDATA),
   .CPU_SLEEP(CPU_SLEEP), .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR),
   .CPU_STALL(CPU_STALL), .NMI_REQ(NMI_REQ));

// File: bench/mcu_memory_check_unit_tb_top.sv
// Register-level testbench of the memory check unit.
// Assumes the flash model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module mcu_memory_check_unit_tb_top;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, cpu_sleep, boot_req;
   logic freq, fvalid, stall, nmi;
   logic [1:0] boot_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] faddr, frdata, chk_addr, chk_word;
   int mismatches = 0, n_tests = 0, nreq = 0, cyc = 0;
   // Short sections keep each scan to a few dozen cycles
   logic [15:0] ends [3] = '{16'h9, 16'h5, 16'h3};

   mcu_memory_check_unit DUT (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CPU_SLEEP(cpu_sleep), .BOOT_SCAN_REQ(boot_req),
      .BOOT_SCAN_SEL(boot_sel), .FLASH_REQ(freq), .FLASH_ADDR(faddr), .FLASH_RDATA(frdata),
      .FLASH_VALID(fvalid), .CPU_STALL(stall), .NMI_REQ(nmi));
   mcu_flash_model u_flash (.clk(mclk), .req(freq), .addr(faddr), .rdata(frdata),
      .valid(fvalid), .chk_addr(chk_addr), .chk_word(chk_word));

   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (freq === 1'b1) nreq++;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   function automatic logic [15:0] crc(input logic [15:0] last);
      logic [15:0] c, w;
      c = 16'hffff;
      for (int a = 0; a < last; a++) begin
         w = {a[7:0], ~a[7:0]} ^ 16'h3c5a;
         for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0);
      end
      return c;
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      cmp(rdat, exp);
   endtask
   task automatic wait_idle;
      // Long enough for the reset-time scan of the whole boot section
      for (int i = 0; i < 1000; i++) begin
         xfer(1'b0, 12'h008, 32'h0);
         if (rdat[0] === 1'b0) break;
      end
      cmp({31'h0, rdat[0]}, 32'h0);
   endtask
   // One check of section s; mid is written to control while busy
   task automatic run(input logic [1:0] s, input logic [7:0] ctl, mid, ectl, est, input bad);
      int n0, n1;
      chk_addr <= ends[s];
      chk_word <= crc(ends[s]) ^ {15'h0, bad};
      n0 = nreq;
      wr(12'h004, {30'h0, s});
      wr(12'h000, {24'h0, ctl});
      rd(12'h008, 32'h1);
      wr(12'h004, 32'h3);
      if (mid != 8'h0) wr(12'h000, {24'h0, mid});
      if (s == 2'h0) begin
         cpu_sleep <= 1'b1;
         repeat (3) @(posedge mclk);
         n1 = nreq;
         repeat (20) @(posedge mclk);
         cmp(nreq - n1, 0);
         cpu_sleep <= 1'b0;
      end
      wait_idle;
      cmp(nreq - n0, ends[s] + 1);
      rd(12'h004, {30'h0, s});
      rd(12'h000, {24'h0, ectl});
      rd(12'h008, {24'h0, est});
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cpu_sleep = 1'b0;
      boot_req = 1'b0;
      boot_sel = 2'h2;
      chk_addr = 16'h01ff;
      chk_word = crc(16'h01ff);
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'h2);
      wr(12'h008, 32'h0);
      rd(12'h008, 32'h2);
      xfer(1'b0, 12'h020, 32'h0);
      cmp({31'h0, pslverr}, 32'h0);
      $display("test registers done");
      boot_req <= 1'b1;
      @(posedge mclk);
      boot_req <= 1'b0;
      wait_idle;
      rd(12'h000, 32'h1);
      rd(12'h004, 32'h12);
      rd(12'h008, 32'h2);
      $display("test boot scan done");
      wr(12'h00c, 32'h9);
      wr(12'h010, 32'h5);
      wr(12'h014, 32'h3);
      run(2'h0, 8'h01, 8'h00, 8'h01, 8'h02, 1'b0);
      run(2'h1, 8'h01, 8'h00, 8'h01, 8'h02, 1'b0);
      run(2'h2, 8'h01, 8'h02, 8'h00, 8'h02, 1'b0);
      $display("test sections done");
      wr(12'h004, 32'h1);
      wr(12'h000, 32'h1);
      wr(12'h000, 32'h80);
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      xfer(1'b0, 12'h008, 32'h0);
      cmp({31'h0, rdat[0]}, 32'h0);
      wr(12'h000, 32'h2);
      rd(12'h000, 32'h2);
      run(2'h2, 8'h03, 8'h82, 8'h02, 8'h02, 1'b0);
      wr(12'h000, 32'h80);
      rd(12'h000, 32'h2);
      $display("test soft reset done");
      run(2'h1, 8'h03, 8'h00, 8'h03, 8'h00, 1'b1);
      cmp({31'h0, nmi}, 32'h1);
      wr(12'h000, 32'h0);
      rd(12'h000, 32'h3);
      wr(12'h004, 32'h2);
      rd(12'h004, 32'h1);
      $display("test failure done");
      nrst <= 1'b0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      cmp({31'h0, nmi}, 32'h0);
      rd(12'h000, 32'h0);
      $display("test system reset done");
      end_of_test();
   end
endmodule
